// ===== fid_float_instruction_datapath.sv
// Floating instruction execution datapath with accumulators and memory operand handshake
`timescale 1ns/1ps
module fid_float_instruction_datapath
  import fid_pkg::*;
#(
  parameter int NUM_ACC = NUM_ACC_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire fid_instr_s instr,
  output logic instr_ready,
  output logic instr_done,
  output logic mem_rd_req,
  input wire logic mem_rd_valid,
  input wire logic [WORD_W-1:0] mem_rd_data,
  output logic mem_wr_req,
  output logic [WORD_W-1:0] mem_wr_data,
  output logic mem_wide,
  input wire logic mem_wr_ack,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata
);
  // Accumulator indices must fit the index field; refused while elaborating
  if (NUM_ACC < 2 || NUM_ACC > (1 << ACC_IDX_W)) begin : g_num_acc_chk
    $error("NUM_ACC out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_EXEC, S_WRITE, S_DONE
  } fid_state_e;

  fid_state_e state_q;
  fid_instr_s cur_q;
  logic [WORD_W-1:0] acc_q [NUM_ACC];
  logic [WORD_W-1:0] mem_q;
  logic [2:0] ctrl_q;
  fid_flags_s flags_q;
  logic [2:0] trap_q;
  logic [WORD_W-1:0] wr_data_q;

  // Normalise a 48-bit fraction (point above bit 47) into a single word
  function automatic fid_pk_s fid_pack(input logic s, input logic signed [10:0] e,
                                       input logic [47:0] m);
    fid_pk_s r;
    int p;
    logic [47:0] mn;
    logic signed [10:0] en;
    r.word = '0;
    r.ovf = 1'b0;
    p = -1;
    mn = m;
    en = e;
    for (int i = 0; i < 48; i++) begin
      if (m[i]) begin
        p = i;
      end
    end
    if (p >= 0) begin
      mn = m << (47 - p);
      en = e - 11'(47 - p);
      if (en > EXP_MAX_S) begin
        r.ovf = 1'b1;
      end else if (en > 11'sh000) begin
        r.word = {s, en[7:0], mn[46:24], 32'h0};
      end
    end
    return r;
  endfunction

  // Hidden-bit fraction of the single segment, zero for a zero exponent
  function automatic logic [23:0] fid_frac(input logic [WORD_W-1:0] w);
    return (w[EXP_HI:EXP_LO] == 8'h00) ? 24'h0 : {1'b1, w[FRAC_HI:SGL_LO]};
  endfunction

  function automatic logic signed [10:0] fid_exp(input logic [WORD_W-1:0] w);
    return signed'({3'b000, w[EXP_HI:EXP_LO]});
  endfunction

  // Signed-magnitude add; the larger magnitude sets sign and exponent
  function automatic fid_pk_s fid_add(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    logic [48:0] mg, ms, sm;
    logic [WORD_W-1:0] g, l;
    logic [7:0] d;
    g = a;
    l = b;
    if ({b[EXP_HI:EXP_LO], fid_frac(b)} > {a[EXP_HI:EXP_LO], fid_frac(a)}) begin
      g = b;
      l = a;
    end
    d = g[EXP_HI:EXP_LO] - l[EXP_HI:EXP_LO];
    mg = {1'b0, fid_frac(g), 24'h0};
    ms = {1'b0, fid_frac(l), 24'h0} >> d;
    sm = (g[SIGN_BIT] == l[SIGN_BIT]) ? mg + ms : mg - ms;
    return fid_pack(g[SIGN_BIT], fid_exp(g) + 11'sh001, sm[48:1]);
  endfunction

  function automatic fid_pk_s fid_mul(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    logic [47:0] pr;
    pr = fid_frac(a) * fid_frac(b);
    return fid_pack(a[SIGN_BIT] ^ b[SIGN_BIT], fid_exp(a) + fid_exp(b) - BIAS_S, pr);
  endfunction

  // Divide by zero reports overflow and yields zero
  function automatic fid_pk_s fid_div(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    fid_pk_s r;
    logic [47:0] q;
    r.word = '0;
    r.ovf = 1'b1;
    q = '0;
    if (b[EXP_HI:EXP_LO] != 8'h00) begin
      q = {fid_frac(a), 24'h0} / {24'h0, fid_frac(b)};
      r = fid_pack(a[SIGN_BIT] ^ b[SIGN_BIT],
                   fid_exp(a) - fid_exp(b) + BIAS_S + 11'sh001, {q[24:0], 23'h0});
    end
    return r;
  endfunction

  // Double to single: drop low segment, or round on its top bit
  function automatic logic [WORD_W-1:0] fid_narrow(input logic [WORD_W-1:0] w,
                                                   input logic trunc);
    logic [31:0] hi;
    hi = w[WORD_W-1:SGL_LO];
    if (!trunc) begin
      hi = hi + {31'h0, w[SEG_MSB]};
    end
    return {hi, 32'h0};
  endfunction

  // Flags that every value-producing operation reports
  function automatic fid_flags_s fid_flags(input logic [WORD_W-1:0] w, input logic ovf);
    fid_flags_s f;
    f.neg = w[SIGN_BIT];
    f.zero = (w[EXP_HI:EXP_LO] == 8'h00);
    f.ovf = ovf;
    f.carry = 1'b0;
    return f;
  endfunction

  // Memory traffic per operation: only absolute and negate do both
  function automatic logic fid_reads_mem(input fid_instr_s i);
    return !i.mode_zero && !(i.op inside {OP_STORE, OP_STORE_NARROW, OP_STORE_WIDEN,
                                          OP_CLEAR});
  endfunction

  function automatic logic fid_writes_mem(input fid_instr_s i);
    return !i.mode_zero && (i.op inside {OP_STORE, OP_STORE_NARROW, OP_STORE_WIDEN,
                                         OP_CLEAR, OP_ABS, OP_NEG});
  endfunction

  // Execute-stage signals
  logic [WORD_W-1:0] opnd, acv, res, res2;
  logic [ACC_IDX_W-1:0] widx, widx2;
  logic we, we2, set_flags, trap_ovf, trap_unf, trap_uv;
  fid_flags_s flg;
  fid_pk_s ar, pm, fr;
  logic [22:0] split_mask;
  logic signed [10:0] split_k;
  logic [15:0] xsrc;
  logic [7:0] xsum;

  // Single format ignores the low segment of the operand
  always_comb begin
    opnd = cur_q.mode_zero ? acc_q[cur_q.opnd_idx] : mem_q;
    if (!ctrl_q[CTL_DOUBLE]) begin
      opnd[SEG_MSB:0] = 32'h0;
    end
  end

  assign acv = acc_q[cur_q.ac_idx];

  // Operation decode and result forming
  always_comb begin
    res = '0;
    res2 = '0;
    widx = cur_q.ac_idx;
    widx2 = cur_q.ac_idx;
    we = 1'b0;
    we2 = 1'b0;
    set_flags = 1'b1;
    trap_ovf = 1'b0;
    trap_unf = 1'b0;
    trap_uv = 1'b0;
    ar = '0;
    fr = '0;
    pm = fid_mul(opnd, acv);
    split_k = fid_exp(pm.word) - BIAS_S;
    split_mask = '0;
    xsrc = opnd[WORD_W-1:WORD_W-16];
    xsum = xsrc[7:0] + EXP_BIAS;
    flg = '0;
    case (cur_q.op)
      OP_ADD, OP_SUB, OP_MUL, OP_DIV: begin
        case (cur_q.op)
          OP_ADD: ar = fid_add(acv, opnd);
          OP_SUB: ar = fid_add(acv, {~opnd[SIGN_BIT], opnd[EXP_HI:0]});
          OP_MUL: ar = fid_mul(acv, opnd);
          default: ar = fid_div(acv, opnd);
        endcase
        res = ar.word;
        we = 1'b1;
        flg = fid_flags(res, ar.ovf);
      end
      OP_CMP: begin
        // Flags only; neither operand is rewritten
        ar = fid_add(opnd, {~acv[SIGN_BIT], acv[EXP_HI:0]});
        flg = fid_flags(ar.word, 1'b0);
      end
      OP_MULTIPLY_SPLIT: begin
        widx = {cur_q.ac_idx[ACC_IDX_W-1:1], 1'b0};
        widx2 = {cur_q.ac_idx[ACC_IDX_W-1:1], 1'b1};
        if (split_k <= 11'sh000) begin
          res = pm.word;
        end else if (split_k >= 11'sh018) begin
          res2 = pm.word;
        end else begin
          // Bits under the binary point move to the fraction part
          split_mask = 23'(24'h1 << (24 - split_k[4:0])) - 23'h1;
          res2 = {pm.word[WORD_W-1:FRAC_HI+1], pm.word[FRAC_HI:SGL_LO] & ~split_mask,
                  32'h0};
          fr = fid_pack(pm.word[SIGN_BIT], fid_exp(pm.word),
                        {1'b0, pm.word[FRAC_HI:SGL_LO] & split_mask, 24'h0});
          res = fr.word;
        end
        we = 1'b1;
        we2 = 1'b1;
        flg = fid_flags(res, pm.ovf);
      end
      OP_LOAD: begin
        res = opnd;
        we = 1'b1;
        flg = fid_flags(res, 1'b0);
      end
      OP_LOAD_NARROW: begin
        res = fid_narrow(cur_q.mode_zero ? acc_q[cur_q.opnd_idx] : mem_q,
                         ctrl_q[CTL_TRUNC]);
        we = 1'b1;
        flg = fid_flags(res, 1'b0);
      end
      OP_LOAD_WIDEN: begin
        res = {opnd[WORD_W-1:SGL_LO], 32'h0};
        we = 1'b1;
        flg = fid_flags(res, 1'b0);
      end
      OP_STORE, OP_STORE_NARROW, OP_STORE_WIDEN: begin
        if (cur_q.op == OP_STORE_NARROW) begin
          res = fid_narrow(acv, ctrl_q[CTL_TRUNC]);
        end else if (cur_q.op == OP_STORE_WIDEN) begin
          res = {acv[WORD_W-1:SGL_LO], 32'h0};
        end else begin
          res = acv;
        end
        widx = cur_q.opnd_idx;
        we = cur_q.mode_zero;
        flg = fid_flags(res, 1'b0);
      end
      OP_CLEAR: begin
        res = '0;
        widx = cur_q.opnd_idx;
        we = cur_q.mode_zero;
        flg = fid_flags(res, 1'b0);
      end
      OP_TEST: begin
        flg = fid_flags(opnd, 1'b0);
        trap_uv = ctrl_q[CTL_UV_EN] && opnd[SIGN_BIT] &&
                  (opnd[EXP_HI:EXP_LO] == 8'h00);
      end
      OP_ABS, OP_NEG: begin
        res = {(cur_q.op == OP_NEG) ? ~opnd[SIGN_BIT] : 1'b0, opnd[EXP_HI:0]};
        if (opnd[EXP_HI:EXP_LO] == 8'h00) begin
          res = '0;
        end
        widx = cur_q.opnd_idx;
        we = cur_q.mode_zero;
        flg = fid_flags(res, 1'b0);
      end
      OP_LOAD_BIASED_EXP: begin
        res = {acv[SIGN_BIT], xsum, acv[FRAC_HI:0]};
        if (xsrc[15:16-LOAD_BIASED_EXPONENT_OP_HI_BITS] == '0) begin
          we = 1'b1;
        end else if (xsrc[15:16-LOAD_BIASED_EXPONENT_OP_HI_BITS] == '1 && xsrc != LOAD_BIASED_EXPONENT_OP_ZERO_EXP) begin
          we = 1'b1;
        end else if (xsrc[15]) begin
          trap_unf = 1'b1;
        end else begin
          trap_ovf = 1'b1;
        end
        flg = fid_flags(we ? res : acv, trap_ovf);
      end
      default: begin
        set_flags = 1'b0;
      end
    endcase
  end

  // Sequencer: fetch, execute, write back, then report completion
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (instr_valid) begin
            state_q <= fid_reads_mem(instr) ? S_FETCH : S_EXEC;
          end
        end
        S_FETCH: begin
          if (mem_rd_valid) begin
            state_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_q <= fid_writes_mem(cur_q) ? S_WRITE : S_DONE;
        end
        S_WRITE: begin
          if (mem_wr_ack) begin
            state_q <= S_DONE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Instruction and fetched operand capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_q <= '0;
      mem_q <= '0;
    end else begin
      if (state_q == S_IDLE && instr_valid) begin
        cur_q <= instr;
      end
      if (state_q == S_FETCH && mem_rd_valid) begin
        mem_q <= mem_rd_data;
      end
    end
  end

  // Accumulator file; the split operation writes a pair
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= '0;
      end
    end else if (state_q == S_EXEC) begin
      if (we) begin
        acc_q[widx] <= res;
      end
      if (we2) begin
        acc_q[widx2] <= res2;
      end
    end
  end

  // Memory handshake outputs, held until the host answers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem_rd_req <= 1'b0;
      mem_wr_req <= 1'b0;
      wr_data_q <= '0;
    end else begin
      mem_rd_req <= (state_q == S_IDLE && instr_valid && fid_reads_mem(instr)) ||
                    (state_q == S_FETCH && !mem_rd_valid);
      mem_wr_req <= (state_q == S_EXEC && fid_writes_mem(cur_q)) ||
                    (state_q == S_WRITE && !mem_wr_ack);
      if (state_q == S_EXEC) begin
        wr_data_q <= res;
      end
    end
  end

  assign mem_wr_data = wr_data_q;

  // Ready and done; the host must wait for done before the next issue
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      instr_ready <= 1'b0;
      instr_done <= 1'b0;
      mem_wide <= 1'b0;
    end else begin
      instr_ready <= (state_q == S_IDLE && !instr_valid) || state_q == S_DONE;
      instr_done <= (state_q == S_DONE);
      mem_wide <= ctrl_q[CTL_DOUBLE];
    end
  end

  // Control register; mode bits should not change mid-instruction
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end
  end

  // Condition flags follow the last decoded operation, compare and test included
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else if (state_q == S_EXEC && set_flags) begin
      flags_q <= flg;
    end
  end

  // Sticky trap bits; write one clears, a new trap in the same cycle wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trap_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_TRAP_OVF + i]) begin
          trap_q[i] <= 1'b0;
        end
      end
      if (state_q == S_EXEC) begin
        if (trap_ovf) begin
          trap_q[0] <= 1'b1;
        end
        if (trap_unf) begin
          trap_q[1] <= 1'b1;
        end
        if (trap_uv) begin
          trap_q[2] <= 1'b1;
        end
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {13'h0, ctrl_q};
        REG_STATUS: reg_rdata <= {4'h0, state_q != S_IDLE, trap_q, 4'h0, flags_q};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ===== fid_float_instruction_datapath_sva.sv
// Assertions on the instruction and memory handshakes of the datapath
`timescale 1ns/1ps
module fid_float_instruction_datapath_sva
  import fid_pkg::*;
#(
  parameter int NUM_ACC = NUM_ACC_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire fid_instr_s instr,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic mem_rd_req,
  input wire logic mem_rd_valid,
  input wire logic mem_wr_req,
  input wire logic [WORD_W-1:0] mem_wr_data,
  input wire logic mem_wr_ack,
  input wire logic reg_rd,
  input wire logic [REG_DATA_W-1:0] reg_rdata
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("instr_done high for more than one cycle");
  a_take_busy: assert property (instr_valid && instr_ready |=> !instr_ready [*2])
    else $error("instr_ready stayed high after an issue");
  a_done_idle: assert property (instr_done |-> instr_ready)
    else $error("instr_done without instr_ready");
  a_arith_time: assert property (instr_valid && instr_ready && instr.mode_zero &&
    instr.op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV} |-> ##3 instr_done)
    else $error("accumulator arithmetic did not finish in three cycles");
  a_mode0_local: assert property (instr_valid && instr_ready && instr.mode_zero
    |=> (!mem_rd_req && !mem_wr_req) [*3])
    else $error("memory touched by an accumulator-only instruction");
  a_rd_hold: assert property (mem_rd_req && !mem_rd_valid |=> mem_rd_req)
    else $error("read request dropped before the host answered");
  a_rd_release: assert property (mem_rd_req && mem_rd_valid |=> !mem_rd_req)
    else $error("read request held after the host answered");
  a_wr_hold: assert property (mem_wr_req && !mem_wr_ack
    |=> mem_wr_req && $stable(mem_wr_data))
    else $error("write request or data changed before the acknowledge");
  a_wr_finish: assert property (mem_wr_req && mem_wr_ack |=> !mem_wr_req ##1 instr_done)
    else $error("write completion out of step");
  a_rw_apart: assert property (!(mem_rd_req && mem_wr_req))
    else $error("read and write requested together");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data shown without a read strobe");
endmodule

bind fid_float_instruction_datapath fid_float_instruction_datapath_sva
  #(.NUM_ACC(NUM_ACC)) u_sva (
  .clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .instr_done(instr_done), .mem_rd_req(mem_rd_req),
  .mem_rd_valid(mem_rd_valid), .mem_wr_req(mem_wr_req), .mem_wr_data(mem_wr_data),
  .mem_wr_ack(mem_wr_ack), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ===== fid_float_instruction_datapath_tb_top.sv
// Self-checking testbench for the floating instruction datapath
`timescale 1ns/1ps
module fid_float_instruction_datapath_tb_top
  import fid_pkg::*;
;
  localparam logic [63:0] ONE = 64'h4080_0000_0000_0000;
  localparam logic [63:0] TWO = 64'h4100_0000_0000_0000;
  localparam logic [63:0] THREE = 64'h4140_0000_0000_0000;
  localparam logic [63:0] FOUR = 64'h4180_0000_0000_0000;
  localparam logic [63:0] NEG_ONE = 64'hc080_0000_0000_0000;
  localparam logic [63:0] W_RND = 64'h4080_0000_8000_0001;
  localparam logic [63:0] RND_UP = 64'h4080_0001_0000_0000;
  localparam logic [63:0] ZX_NEG = 64'h8012_3400_0000_0000;
  logic clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  fid_instr_s instr = '0;
  logic instr_ready, instr_done, mem_rd_req, mem_rd_valid, mem_wr_req, mem_wide, mem_wr_ack;
  logic [63:0] mem_rd_data, mem_wr_data, wr_word;
  logic [63:0] rd_word = '0;
  logic [3:0] reg_addr = '0, dly = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, st;
  int rd_cnt, wr_cnt, r0, w0, error_cnt = 0, n_checks = 0, cyc = 0;

  fid_float_instruction_datapath #(.NUM_ACC(NUM_ACC_DEF)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .instr_done(instr_done), .mem_rd_req(mem_rd_req),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .mem_wr_req(mem_wr_req),
    .mem_wr_data(mem_wr_data), .mem_wide(mem_wide), .mem_wr_ack(mem_wr_ack),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  fid_host_model u_host (
    .clock(clock), .sys_rst(sys_rst), .mem_rd_req(mem_rd_req), .mem_wr_req(mem_wr_req),
    .mem_wr_data(mem_wr_data), .rd_word(rd_word), .dly(dly), .mem_rd_valid(mem_rd_valid),
    .mem_wr_ack(mem_wr_ack), .mem_rd_data(mem_rd_data), .wr_word(wr_word),
    .rd_cnt(rd_cnt), .wr_cnt(wr_cnt)
  );

  // 20 MHz clock
  always #25 clock = ~clock;

  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register port: one-cycle strobes, read data in the cycle after
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    st = reg_rdata;
  endtask

  // Issue one instruction and wait, bounded, for its done pulse
  task automatic run(input fid_op_e op, input logic mz, input logic [2:0] ac,
                     input logic [2:0] od);
    int n;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= '{op, mz, ac, od};
    @(posedge clock);
    instr_valid <= 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk("instr_done", {63'h0, n < 100}, 64'h1);
  endtask

  task automatic put(input logic [2:0] ac, input logic [63:0] w);
    rd_word <= w;
    run(OP_LOAD, 1'b0, ac, 3'h0);
  endtask
  task automatic get(input logic [2:0] ac, input logic [63:0] exp);
    run(OP_STORE, 1'b0, ac, 3'h0);
    chk("stored word", wr_word, exp);
  endtask
  task automatic arith(input fid_op_e op, input logic [63:0] src, input logic [63:0] exp);
    rd_word <= src;
    run(op, 1'b0, 3'h0, 3'h0);
    get(3'h0, exp);
  endtask

  // One operand transform, with the memory traffic it caused
  task automatic xfer(input fid_op_e op, input logic mz, input logic [2:0] ctl,
                      input logic [63:0] w, input logic [63:0] exp);
    logic sto, rmw;
    sto = op inside {OP_STORE_NARROW, OP_STORE_WIDEN};
    rmw = !mz && op inside {OP_ABS, OP_NEG};
    reg_write(REG_CTRL, {13'h0, ctl});
    if (sto || mz) put(3'h1, w);
    else rd_word <= w;
    r0 = rd_cnt;
    w0 = wr_cnt;
    run(op, mz, 3'h1, 3'h1);
    chk("reads", rd_cnt - r0, {63'h0, !sto && !mz});
    chk("writes", wr_cnt - w0, {63'h0, sto || rmw});
    if (sto || rmw) chk("memory word", wr_word, exp);
    else get(3'h1, exp);
  endtask

  // Load exponent, then the overflow/underflow trap bits
  task automatic lde(input logic [15:0] src, input logic [63:0] exp, input logic [2:0] trap);
    put(3'h2, ONE);
    rd_word <= {src, 48'h0};
    run(OP_LOAD_BIASED_EXP, 1'b0, 3'h2, 3'h0);
    get(3'h2, exp);
    reg_read(REG_STATUS);
    chk("exponent traps", st[10:8], trap);
    reg_write(REG_STATUS, 16'h0700);
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    reg_read(REG_CTRL);
    chk("ctrl reset", st, 16'h0);
    reg_read(REG_STATUS);
    chk("status reset", st, 16'h0);
    reg_write(REG_CTRL, 16'h0007);
    reg_read(REG_CTRL);
    chk("ctrl readback", st, 16'h0007);
    reg_read(4'h9);
    chk("unmapped read", st, 16'h0);
    reg_write(REG_CTRL, 16'h0002);
    put(3'h0, ONE);
    chk("mem_wide", mem_wide, 64'h1);
    put(3'h1, ONE);
    run(OP_ADD, 1'b1, 3'h0, 3'h1);
    get(3'h0, TWO);
    arith(OP_ADD, ONE, THREE);
    arith(OP_SUB, ONE, TWO);
    arith(OP_MUL, TWO, FOUR);
    arith(OP_DIV, TWO, TWO);
    w0 = wr_cnt;
    rd_word <= ONE;
    run(OP_CMP, 1'b0, 3'h0, 3'h0);
    chk("compare writes", wr_cnt - w0, 64'h0);
    get(3'h0, TWO);
    put(3'h2, 64'h4120_0000_0000_0000);
    rd_word <= ONE;
    run(OP_MULTIPLY_SPLIT, 1'b0, 3'h2, 3'h0);
    get(3'h3, TWO);
    get(3'h2, 64'h4000_0000_0000_0000);
    put(3'h4, THREE);
    run(OP_STORE, 1'b1, 3'h4, 3'h5);
    get(3'h5, THREE);
    dly <= 4'h3;
    xfer(OP_LOAD, 1'b0, 3'h2, W_RND, W_RND);
    xfer(OP_LOAD_NARROW, 1'b0, 3'h2, W_RND, RND_UP);
    xfer(OP_LOAD_NARROW, 1'b0, 3'h3, W_RND, ONE);
    xfer(OP_LOAD_NARROW, 1'b0, 3'h2, 64'h4080_0000_7fff_ffff, ONE);
    xfer(OP_LOAD_WIDEN, 1'b0, 3'h2, W_RND, ONE);
    xfer(OP_STORE_NARROW, 1'b0, 3'h2, W_RND, RND_UP);
    xfer(OP_STORE_NARROW, 1'b0, 3'h3, W_RND, ONE);
    xfer(OP_STORE_WIDEN, 1'b0, 3'h2, W_RND, ONE);
    xfer(OP_ABS, 1'b0, 3'h2, NEG_ONE, ONE);
    xfer(OP_ABS, 1'b0, 3'h2, ZX_NEG, 64'h0);
    xfer(OP_NEG, 1'b0, 3'h2, ONE, NEG_ONE);
    xfer(OP_NEG, 1'b0, 3'h2, 64'h0012_3400_0000_0000, 64'h0);
    xfer(OP_ABS, 1'b1, 3'h2, NEG_ONE, ONE);
    xfer(OP_NEG, 1'b1, 3'h2, ZX_NEG, 64'h0);
    xfer(OP_NEG, 1'b1, 3'h2, ONE, NEG_ONE);
    xfer(OP_CLEAR, 1'b1, 3'h2, W_RND, 64'h0);
    reg_write(REG_CTRL, 16'h0004);
    put(3'h5, 64'h8000_0000_0000_0000);
    rd_word <= 64'h0;
    run(OP_DIV, 1'b0, 3'h0, 3'h0);
    reg_read(REG_STATUS);
    chk("divide overflow", st[1], 1'b1);
    run(OP_TEST, 1'b1, 3'h0, 3'h5);
    reg_read(REG_STATUS);
    chk("test flags", st[3:0], 4'hc);
    chk("minus zero trap", st[10], 1'b1);
    reg_write(REG_STATUS, 16'h0700);
    reg_write(REG_CTRL, 16'h0000);
    put(3'h5, NEG_ONE);
    chk("mem_wide", mem_wide, 64'h0);
    run(OP_TEST, 1'b1, 3'h0, 3'h5);
    reg_read(REG_STATUS);
    chk("test flags", st[3:0], 4'h8);
    chk("minus zero trap", st[10], 1'b0);
    lde(16'h001c, 64'h4e00_0000_0000_0000, 3'h0);
    lde(16'hff81, 64'h0080_0000_0000_0000, 3'h0);
    lde(16'h0081, ONE, 3'h1);
    lde(16'h8080, ONE, 3'h2);
    lde(16'hff80, ONE, 3'h2);
    wrap_up();
  end
endmodule

// ===== fid_host_model.sv
// Behavioural host that answers the datapath's memory operand handshake
`timescale 1ns/1ps
module fid_host_model
  import fid_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mem_rd_req,
  input wire logic mem_wr_req,
  input wire logic [WORD_W-1:0] mem_wr_data,
  input wire logic [WORD_W-1:0] rd_word,
  input wire logic [3:0] dly,
  output logic mem_rd_valid = 1'b0,
  output logic mem_wr_ack = 1'b0,
  output logic [WORD_W-1:0] mem_rd_data = '0,
  output logic [WORD_W-1:0] wr_word = '0,
  output int rd_cnt = 0,
  output int wr_cnt = 0
);
  logic [3:0] wait_q = '0;

  // Answer a pending request after dly cycles with a one-cycle pulse
  always @(posedge clock) begin
    mem_rd_valid <= 1'b0;
    mem_wr_ack <= 1'b0;
    mem_rd_data <= ~mem_rd_data; // Released lines toggle, so stale data never looks good
    if (sys_rst) begin
      wait_q <= '0;
    end else if ((mem_rd_req || mem_wr_req) && !mem_rd_valid && !mem_wr_ack) begin
      if (wait_q < dly) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= '0;
        mem_rd_valid <= mem_rd_req;
        mem_wr_ack <= mem_wr_req;
        if (mem_rd_req) begin
          mem_rd_data <= rd_word;
        end
      end
    end
  end

  // Count finished transfers so read-modify-write traffic can be seen
  always @(posedge clock) begin
    if (mem_rd_req && mem_rd_valid) begin
      rd_cnt <= rd_cnt + 1;
    end
    if (mem_wr_req && mem_wr_ack) begin
      wr_word <= mem_wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

// ===== fid_pkg.sv
// Shared types and constants for the floating instruction datapath
package fid_pkg;
  // Operand word layout
  localparam int WORD_W = 64;
  localparam int SIGN_BIT = 63;
  localparam int EXP_HI = 62;
  localparam int EXP_LO = 55;
  localparam int FRAC_HI = 54;
  localparam int SGL_LO = 32;
  localparam int SEG_MSB = 31;
  localparam int ACC_IDX_W = 3;
  localparam int NUM_ACC_DEF = 6;
  // Excess-200 octal bias and derived limits
  localparam logic [7:0] EXP_BIAS = 8'h80;
  localparam logic signed [10:0] BIAS_S = 11'sh080;
  localparam logic signed [10:0] EXP_MAX_S = 11'sh0ff;
  localparam logic [15:0] LOAD_BIASED_EXPONENT_OP_ZERO_EXP = 16'hff80;
  localparam int LOAD_BIASED_EXPONENT_OP_HI_BITS = 9;
  // Register port map (word indices)
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  // Control register fields
  localparam int CTL_TRUNC = 0;
  localparam int CTL_DOUBLE = 1;
  localparam int CTL_UV_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status register fields
  localparam int ST_CARRY = 0;
  localparam int ST_OVF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_NEG = 3;
  localparam int ST_TRAP_OVF = 8;
  localparam int ST_TRAP_UNF = 9;
  localparam int ST_TRAP_UV = 10;
  localparam int ST_BUSY = 11;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_CMP, OP_MULTIPLY_SPLIT,
    OP_LOAD, OP_STORE, OP_LOAD_NARROW, OP_LOAD_WIDEN,
    OP_STORE_NARROW, OP_STORE_WIDEN, OP_CLEAR, OP_TEST,
    OP_ABS, OP_NEG, OP_LOAD_BIASED_EXP
  } fid_op_e;

  // One issued instruction
  typedef struct packed {
    fid_op_e op;
    logic mode_zero;
    logic [ACC_IDX_W-1:0] ac_idx;
    logic [ACC_IDX_W-1:0] opnd_idx;
  } fid_instr_s;

  // Result of an arithmetic helper
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic ovf;
  } fid_pk_s;

  // Condition flags
  typedef struct packed {
    logic neg;
    logic zero;
    logic ovf;
    logic carry;
  } fid_flags_s;
endpackage
